// *** verilog/window_watchdog_pkg.sv ***
// Constants, register map and state layout of the window watchdog.
package window_watchdog_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam logic [3:0] WD_CONTROL_OFS = 4'h0;
  localparam logic [3:0] WINDOW_LIMIT_OFS = 4'h4;
  localparam logic [3:0] WD_STATUS_OFS = 4'h8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ACTIVATION_BIT_POS = 7;
  localparam int COUNTER_TOP_BIT_POS = 6;
  localparam int STAT_ENABLED_POS = 0;
  localparam int STAT_RESETTING_POS = 1;
  localparam logic [6:0] COUNTER_RST_VAL = 7'h7F;
  localparam logic [6:0] WINDOW_RST_VAL = 7'h7F;
  localparam logic [6:0] COUNTER_EXPIRE_VAL = 7'h40;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int RST_PULSE_NS = 30000;
  localparam int RST_PULSE_CYC_DEF = RST_PULSE_NS * CLK_MHZ / 1000;
  // One prescaler period is 256 units of 64 oscillator ticks (16384 ticks).
  localparam int PRESC_UNIT_DEF = 64;
  localparam int PRESC_UNITS = 256;
  localparam int PRESC_MIN_BASE = 128;
  localparam int OSC_DIV_DEF = 31;

  // Phase offset (in prescaler units) per timebase selection.
  localparam logic [7:0] TB_LSB_0 = 8'h3B;
  localparam logic [7:0] TB_LSB_1 = 8'h35;
  localparam logic [7:0] TB_LSB_2 = 8'h23;
  localparam logic [7:0] TB_LSB_3 = 8'h36;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    ST_RUN = 1'b0,
    ST_PULSE = 1'b1
  } wd_state_e;

  typedef struct packed {
    wd_state_e st;
    logic [7:0] osc_div;
    logic [11:0] unit_cnt;
    logic [7:0] unit_idx;
    logic [7:0] guard;
    logic guard_on;
    logic owed;
    logic act;
    logic [6:0] cnt;
    logic [6:0] win;
    logic [15:0] pulse_cnt;
    logic ack;
    logic [31:0] rdata;
  } wd_state_s;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avmm_req_s;

endpackage

// *** verilog/window_watchdog.sv ***
// Window watchdog with Avalon-MM register access.
`timescale 1ns/1ps
`default_nettype none

// Low-power modes are not modelled: the counter never pauses, so a system
// that stops the CPU in halt must gate this block's clock itself.
module window_watchdog
  import window_watchdog_pkg::*;
#(
  parameter int RST_PULSE_CYC = RST_PULSE_CYC_DEF,
  parameter int PRESC_UNIT = PRESC_UNIT_DEF,
  parameter int OSC_DIV = OSC_DIV_DEF
) (
  // Everything runs on one clock with a synchronous reset.
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Software reaches the registers through this Avalon-MM slave.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Option byte levels, the timebase choice and the CPU's HALT report.
  input wire logic hw_watchdog_opt_i,
  input wire logic halt_reset_option_i,
  input wire logic [1:0] timebase_select_i,
  input wire logic halt_exec_i,
  output logic halt_enter_o,
  // The reset request is active low and comes from a register.
  output logic wd_reset_n_o
);

  // ----------------------------------------------------------------
  // State and combinational terms
  // ----------------------------------------------------------------
  wd_state_s s_r;
  wd_state_s s_nxt;
  avmm_req_s req;
  // Activation, prescaler enables and the step strobe follow.
  logic active;
  logic osc_tick;
  logic unit_tick;
  logic wrap;
  logic step;
  logic ctl_wr;
  logic win_wr;
  logic [7:0] tb_lsb;
  logic [7:0] min_units;
  // The terms below are the new activation bit, the reset causes and their union.
  logic new_act;
  logic expire;
  logic bad_window;
  logic soft_rst;
  logic halt_rst;
  logic fire;
  // Bus qualifier, the two prescaler step paths and the read word.
  logic bus_req;
  logic wrap_step;
  logic late_step;
  logic [31:0] rd_word;

  // The raw Avalon-MM inputs travel together as one request word.
  assign req = '{
    address: avs_address_i,
    read: avs_read_i,
    write: avs_write_i,
    byteenable: avs_byteenable_i,
    writedata: avs_writedata_i
  };
  assign bus_req = req.read || req.write;

  // Hardware option overrides the software bit entirely.
  assign active = hw_watchdog_opt_i | s_r.act;

  // Each timebase sets how early the first step may fall after a write.
  always_comb begin
    unique case (timebase_select_i)
      2'b00: tb_lsb = TB_LSB_0;
      2'b01: tb_lsb = TB_LSB_1;
      2'b10: tb_lsb = TB_LSB_2;
      2'b11: tb_lsb = TB_LSB_3;
    endcase
  end
  assign min_units = tb_lsb + 8'(PRESC_MIN_BASE);

  // ----------------------------------------------------------------
  // Prescaler chain: oscillator enable, 64-tick units, 256-unit period
  // ----------------------------------------------------------------
  assign osc_tick = (s_r.osc_div == 8'(OSC_DIV - 1));
  assign unit_tick = osc_tick && (s_r.unit_cnt == 12'(PRESC_UNIT - 1));
  assign wrap = unit_tick && (s_r.unit_idx == 8'(PRESC_UNITS - 1));

  // ----------------------------------------------------------------
  // Bus decode; action happens in the cycle waitrequest is low
  // ----------------------------------------------------------------
  assign ctl_wr = req.write && s_r.ack && req.byteenable[0] &&
                  (req.address == WD_CONTROL_OFS);
  assign win_wr = req.write && s_r.ack && req.byteenable[0] &&
                  (req.address == WINDOW_LIMIT_OFS);
  assign avs_waitrequest_o = (req.read || req.write) && !s_r.ack;
  assign avs_readdata_o = s_r.rdata;

  // ----------------------------------------------------------------
  // Activation
  // ----------------------------------------------------------------
  // Writing zero to the activation bit changes nothing.
  assign new_act = s_r.act | req.writedata[ACTIVATION_BIT_POS];

  // ----------------------------------------------------------------
  // Reset causes
  // ----------------------------------------------------------------
  // The guard delays a step owed by an early wrap, so the decrement itself
  // is what a step means whichever path produced it.
  assign wrap_step = wrap && !s_r.guard_on;
  // A wrap that lands on the very unit where the guard runs out is taken
  // there and then; deferring it again would stretch the wait past one
  // full period.
  assign late_step = s_r.guard_on && (s_r.guard == 8'h01) && unit_tick &&
                     (s_r.owed || wrap);
  assign step = wrap_step || late_step;
  assign expire = active && step && !ctl_wr &&
                  (s_r.cnt == COUNTER_EXPIRE_VAL);
  assign bad_window = ctl_wr && (hw_watchdog_opt_i | new_act) &&
                      (s_r.cnt > s_r.win);
  assign soft_rst = ctl_wr && (hw_watchdog_opt_i | new_act) &&
                    !req.writedata[COUNTER_TOP_BIT_POS];
  assign halt_rst = halt_exec_i && active && halt_reset_option_i;
  // The CPU may enter halt only when no halt reset is due.
  assign halt_enter_o = halt_exec_i && !halt_rst;
  assign fire = expire ||
                bad_window ||
                soft_rst ||
                halt_rst;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero; this bus has no error response.
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (req.address)
      WD_CONTROL_OFS: begin
        rd_word[ACTIVATION_BIT_POS] = s_r.act;
        rd_word[COUNTER_TOP_BIT_POS:0] = s_r.cnt;
      end
      WINDOW_LIMIT_OFS: begin
        rd_word[6:0] = s_r.win;
      end
      WD_STATUS_OFS: begin
        rd_word[STAT_ENABLED_POS] = active;
        rd_word[STAT_RESETTING_POS] = (s_r.st == ST_PULSE);
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Prescaler is never cleared on a write; only a deferred step below restarts its period.
    if (osc_tick) begin
      s_nxt.osc_div = 8'h00;
    end else begin
      s_nxt.osc_div = s_r.osc_div + 8'h01;
    end
    if (osc_tick) begin
      s_nxt.unit_cnt = unit_tick ? 12'h000 : s_r.unit_cnt + 12'h001;
    end
    if (unit_tick) begin
      s_nxt.unit_idx = s_r.unit_idx + 8'h01;
    end
    // A deferred step starts a fresh period, so the step after it is one
    // whole period later and not at the old, nearer phase.
    if (late_step && s_r.owed) begin
      s_nxt.unit_idx = 8'h00;
    end

    // Guard window after a counter write: a wrap that comes too early is
    // held back until the least time has passed, never beyond one period.
    if (s_r.guard_on && unit_tick) begin
      s_nxt.guard = s_r.guard - 8'h01;
      if (s_r.guard == 8'h01) begin
        s_nxt.guard_on = 1'b0;
        s_nxt.owed = 1'b0;
      end
    end
    if (s_r.guard_on && wrap && s_r.guard != 8'h01) begin
      s_nxt.owed = 1'b1;
    end

    // Counter free-runs regardless of activation; wraps at zero.
    if (step) begin
      s_nxt.cnt = s_r.cnt - 7'h01;
    end

    if (ctl_wr) begin
      s_nxt.act = new_act;
      s_nxt.cnt = req.writedata[6:0];
      s_nxt.guard = min_units;
      s_nxt.guard_on = 1'b1;
      s_nxt.owed = 1'b0;
    end
    // Only the low seven bits of the window limit are kept.
    if (win_wr) begin
      s_nxt.win = req.writedata[6:0];
    end

    // Reset pulse generator. A cause that comes while the pulse runs is
    // dropped, since the chip is being reset anyway.
    unique case (s_r.st)
      ST_RUN: begin
        if (fire) begin
          s_nxt.st = ST_PULSE;
          s_nxt.pulse_cnt = 16'(RST_PULSE_CYC - 1);
        end
      end
      ST_PULSE: begin
        if (s_r.pulse_cnt == 16'h0000) begin
          s_nxt.st = ST_RUN;
        end else begin
          s_nxt.pulse_cnt = s_r.pulse_cnt - 16'h0001;
        end
      end
    endcase

    // Bus answer: one wait cycle, read data captured for the answer edge.
    s_nxt.ack = bus_req && !s_r.ack;
    if (bus_req && !s_r.ack) begin
      s_nxt.rdata = req.read ? rd_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '{
        st: ST_RUN,
        osc_div: 8'h00,
        unit_cnt: 12'h000,
        unit_idx: 8'h00,
        guard: 8'h00,
        guard_on: 1'b0,
        owed: 1'b0,
        act: 1'b0,
        cnt: COUNTER_RST_VAL,
        win: WINDOW_RST_VAL,
        pulse_cnt: 16'h0000,
        ack: 1'b0,
        rdata: 32'h0000_0000
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reset request output
  // ----------------------------------------------------------------
  // Taken straight from the state register, so the pin never glitches.
  assign wd_reset_n_o = (s_r.st != ST_PULSE);

endmodule // window_watchdog

`default_nettype wire

// *** verif/window_watchdog_assertions.sv ***
// Port assertions for the window watchdog.
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_assertions
  import window_watchdog_pkg::*;
#(parameter int RST_PULSE_CYC = 20) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic hw_watchdog_opt_i,
  input wire logic halt_reset_option_i,
  input wire logic halt_exec_i,
  input wire logic halt_enter_o,
  input wire logic wd_reset_n_o
);
  // ----------------------------------------
  // Helpers and checks
  // ----------------------------------------
  wire logic req = avs_read_i || avs_write_i;
  wire logic ans = req && !avs_waitrequest_o;
  wire logic ctl_wr = ans && avs_write_i && avs_address_i == WD_CONTROL_OFS && avs_byteenable_i[0];
  wire logic st_rd = ans && avs_read_i && avs_address_i == WD_STATUS_OFS;
  int low_r;
  logic seen_r;
  // The low count restarts on every high cycle, so its value at a rise is the pulse length.
  always_ff @(posedge sys_clk_i) begin
    low_r <= (sys_rst_i || wd_reset_n_o) ? 0 : low_r + 1;
    seen_r <= !sys_rst_i && (seen_r || (ctl_wr && avs_writedata_i[7]));
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_wait; $rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing wrong");
  property p_unmap; ans && avs_read_i && avs_address_i > 4'h8 |-> avs_readdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_soft; ctl_wr && avs_writedata_i[7:6] == 2'b10 |-> ##[1:2] !wd_reset_n_o; endproperty
  a_soft: assert property (p_soft) else $error("no software reset");
  property p_hwhalt; halt_exec_i && halt_reset_option_i && hw_watchdog_opt_i
    |-> !halt_enter_o ##[1:2] !wd_reset_n_o; endproperty
  a_hwhalt: assert property (p_hwhalt) else $error("halt did not reset");
  property p_halt_ok; halt_exec_i && !halt_reset_option_i |-> halt_enter_o; endproperty
  a_halt_ok: assert property (p_halt_ok) else $error("halt refused");
  property p_sticky; st_rd && seen_r |-> avs_readdata_o[STAT_ENABLED_POS]; endproperty
  a_sticky: assert property (p_sticky) else $error("activation lost");
  property p_pmax; !wd_reset_n_o |-> low_r < RST_PULSE_CYC; endproperty
  a_pmax: assert property (p_pmax) else $error("reset pulse too long");
  property p_plen; $rose(wd_reset_n_o) |-> low_r == RST_PULSE_CYC; endproperty
  a_plen: assert property (p_plen) else $error("reset pulse too short");
endmodule // window_watchdog_assertions
bind window_watchdog window_watchdog_assertions #(.RST_PULSE_CYC(RST_PULSE_CYC)) chk_u (.*);
`default_nettype wire

// *** verif/window_watchdog_tb.sv ***
// Self-checking bench for the window watchdog.
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_tb;
  import window_watchdog_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, hw = 0, opt = 0, hlt = 0, wt, hen, rn, e;
  logic [1:0] tb = 0;
  logic [3:0] adr = 0, be = 0;
  logic [7:0] w, wv[5] = '{8'hC1, 8'h80, 8'h3F, 8'hFF, 8'h3F};
  logic [31:0] wd = 0, rdat, q, lf = 32'h0001_0A0A;
  int miscompares = 0, n_compared = 0, cyc = 0, t, lsb[4] = '{59, 53, 35, 54};
  window_watchdog #(.RST_PULSE_CYC(20), .PRESC_UNIT(1), .OSC_DIV(1)) dut_u (
    .sys_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .hw_watchdog_opt_i(hw),
    .halt_reset_option_i(opt), .timebase_select_i(tb), .halt_exec_i(hlt),
    .halt_enter_o(hen), .wd_reset_n_o(rn));
  // ----------------------------------------
  // Drivers and checks
  // ----------------------------------------
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      test_done;
    end
  end
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Upper data and lane bits are random, since only lane 0 may matter.
  task automatic bus(input logic wrt, input logic [3:0] a, input logic [7:0] d);
    lf = nx(lf);
    adr <= a;
    wd <= {lf[31:8], d};
    be <= {lf[3:1], 1'b1};
    rd <= !wrt;
    wr <= wrt;
    // Only the bench-wide cycle limit may end this wait.
    do begin
      @(posedge clk);
    end while (wt !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic restart(input logic h, input logic o);
    lf = nx(lf);
    rst <= 1;
    hw <= h;
    opt <= o;
    tb <= lf[1:0];
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
  endtask
  task automatic fire(input int lim, input logic x);
    t = 0;
    while (rn !== 1'b0 && t < lim) begin
      @(posedge clk);
      t++;
    end
    ck(!rn, x);
    if (rn === 1'b0) begin
      repeat (20) @(posedge clk);
      ck(rn, 1);
    end
  endtask
  task automatic halt(input logic x);
    hlt <= 1;
    @(posedge clk);
    ck(hen, x);
    hlt <= 0;
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    restart(0, 0);
    bus(0, WD_CONTROL_OFS, 0);
    ck(q, 32'h7F);
    bus(0, WINDOW_LIMIT_OFS, 0);
    ck(q, 32'h7F);
    bus(0, 4'hC, 0);
    ck(q, 0);
    bus(1, WD_CONTROL_OFS, 8'h7F);
    repeat (600) @(posedge clk);
    bus(0, WD_CONTROL_OFS, 0);
    ck(q < 32'h7F && q > 32'h7B, 1);
    fire(4, 0);
    $display("test 1 done");
    for (int i = 0; i < 5; i++) begin
      restart(i == 2, 0);
      w = i ? 8'h7F : 8'h7E;
      bus(1, WINDOW_LIMIT_OFS, w);
      bus(1, WD_CONTROL_OFS, wv[i]);
      e = (i == 2 || wv[i][7]) && (!wv[i][6] || 8'h7F > w);
      fire(4, e);
    end
    $display("test 2 done");
    for (int i = 0; i < 5; i++) begin
      restart(i[1], i[0] | i[2]);
      if (i == 4) bus(1, WD_CONTROL_OFS, 8'hFF);
      e = (i[1] | i[2]) & (i[0] | i[2]);
      halt(!e);
      fire(4, e);
    end
    $display("test 3 done");
    for (int i = 0; i < 3; i++) begin
      restart(0, 0);
      bus(1, WD_CONTROL_OFS, 8'hFF);
      bus(1, WD_CONTROL_OFS, 8'h7F);
      bus(0, WD_STATUS_OFS, 0);
      ck(q[0], 1);
      bus(1, WD_CONTROL_OFS, 8'hC0 | i[7:0]);
      fire(1200, 1);
      ck(t >= lsb[tb] + 128 + 256 * i && t <= 256 + 256 * i, 1);
    end
    $display("test 4 done");
    test_done;
  end
endmodule // window_watchdog_tb
`default_nettype wire
